// ==== bus_master_model.sv ====
/*
  Behavioural two-wire bus master that drives the serial clock and pulls
  the data line low.
  Assumes a pull-up on the data line, which the bench resolves.
*/
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
  // Bus lines
  output logic      scl,
  output logic      pull_low,
  input  wire logic sda
);
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end

  // Data changes 8 ns into the low phase, is sampled mid high
  task automatic clk_bit(input logic drive, output logic seen);
    #8 pull_low = ~drive;
    #16 scl = 1'b1;
    #12 seen = sda;
    #12 scl = 1'b0;
  endtask : clk_bit

  task automatic start_cond;
    #8 pull_low = 1'b0;
    #16 scl = 1'b1;
    #12 pull_low = 1'b1;
    #12 scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    #8 pull_low = 1'b1;
    #16 scl = 1'b1;
    #12 pull_low = 1'b0;
    #24;
  endtask : stop_cond

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send

  task automatic recv(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(~ack, s);
  endtask : recv
endmodule : bus_master_model
`default_nettype wire

// ==== eeprom_params.svh ====
/*
  Constants of the two-wire EEPROM slave: APB map, field positions,
  reset values, protocol widths and timing.
  Assumes inclusion by bare name before any module that uses it.
*/
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// APB register byte offsets
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define APB_OFS_W         12

// CTRL fields
`define CTRL_EXT_LSB      0
`define CTRL_EXT_MSB      1
`define CTRL_EXT_RESET    2'h3

// STATUS fields
`define STAT_BUSY         0
`define STAT_ACTIVE       1
`define STAT_WP           2
`define STAT_ADDR_LSB     16
`define STAT_ADDR_MSB     26

// Protocol shape
`define MEM_ADDR_W        11
`define PAGE_IDX_W        4
`define PAGE_BYTES        16
`define LOW_ADDR_W        8
`define BITS_PER_BYTE     4'h8
`define CHIP_BITS         3
`define ERASED_BYTE       8'hFF
// Type identifier: arbitrary value, not taken from any part
`define TYPE_ID_DEFAULT   4'h5

// Timing
`define CLK_PERIOD_NS     5
`define PROG_TIME_NS      5000000

`endif

// ==== eeprom_pkg.sv ====
/*
  Types shared by the EEPROM slave modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package eeprom_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_RACK
  } state_type;

  typedef enum logic [1:0] {
    K_SEL,
    K_ADDR,
    K_DATA,
    K_READ
  } kind_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } line_events_type;

  typedef struct packed {
    logic       wp;
    logic [2:0] chip;
  } straps_type;

endpackage : eeprom_pkg

// ==== line_watch.sv ====
/*
  Synchronises the two-wire lines and strap pins into pclk and finds
  clock edges, Start and Stop.
  Assumes pclk runs well above the serial clock rate.
*/
`timescale 1ns/100ps
`default_nettype none
module line_watch
  import eeprom_pkg::*;
(
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Raw pins
  input  wire logic            scl,
  input  wire logic            sda_in,
  input  wire logic            write_protect_pin,
  input  wire logic [2:0]      chip_pins,
  // Synchronised view
  output line_events_type      ev,
  output straps_type           straps
);

  logic [5:0] meta;
  logic [5:0] sync;
  logic       scl_prev;
  logic       sda_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= 6'h03;
      sync     <= 6'h03;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      meta     <= {write_protect_pin, chip_pins, sda_in, scl};
      sync     <= meta;
      scl_prev <= sync[0];
      sda_prev <= sync[1];
    end
  end

  wire scl_s = sync[0];
  wire sda_s = sync[1];

  assign ev.rise  = scl_s & ~scl_prev;
  assign ev.fall  = ~scl_s & scl_prev;
  assign ev.start = scl_s & scl_prev & sda_prev & ~sda_s;
  assign ev.stop  = scl_s & scl_prev & ~sda_prev & sda_s;
  assign ev.sda   = sda_s;
  assign straps.wp   = sync[5];
  assign straps.chip = sync[4:2];

  start_needs_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.start |-> scl_s && $past(scl_s) && !ev.rise)
    else $error("start seen without clock high");

endmodule : line_watch
`default_nettype wire

// ==== page_programmer.sv ====
/*
  Memory array, page latch and self-timed programming cycle.
  Assumes loads and commits come from the protocol engine on pclk.
*/
`include "eeprom_params.svh"
`timescale 1ns/100ps
`default_nettype none
module page_programmer
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = 1000000
)(
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Page latch
  input  wire logic                     clear,
  input  wire logic                     load,
  input  wire logic [`PAGE_IDX_W-1:0]   load_idx,
  input  wire logic [7:0]               load_data,
  // Programming
  input  wire logic                     commit,
  input  wire logic [`MEM_ADDR_W-5:0]   commit_base,
  output logic                          busy,
  // Read port
  input  wire logic [`MEM_ADDR_W-1:0]   rd_addr,
  output logic [7:0]                    rd_data
);

  logic [7:0]             mem [2**`MEM_ADDR_W];
  logic [7:0]             page [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] valid;
  logic [31:0]            timer;

  assign rd_data = mem[rd_addr];

  // Array written at commit; the timer then keeps the bus shut out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2**`MEM_ADDR_W; i++) mem[i] <= `ERASED_BYTE;
      for (int i = 0; i < `PAGE_BYTES; i++) page[i] <= `ERASED_BYTE;
      valid <= '0;
      busy  <= 1'b0;
      timer <= '0;
    end else if (busy) begin
      timer <= timer - 32'h1;
      busy  <= (timer != 32'h1);
    end else if (commit) begin
      for (int i = 0; i < `PAGE_BYTES; i++)
        if (valid[i]) mem[{commit_base, `PAGE_IDX_W'(i)}] <= page[i];
      valid <= '0;
      busy  <= 1'b1;
      timer <= 32'(PROG_CYCLES);
    end else if (clear) begin
      valid <= '0;
    end else if (load) begin
      page[load_idx]  <= load_data;
      valid[load_idx] <= 1'b1;
    end
  end

  busy_length_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> busy [*8])
    else $error("programming cycle ended too soon");

endmodule : page_programmer
`default_nettype wire

// ==== serial_eeprom_slave.sv ====
/*
  Two-wire serial EEPROM slave: select decode, byte and page writes,
  current, random and sequential reads, APB control and status.
  Assumes straps are static and the serial clock is far below pclk.
*/
// Implementation choices: the placing of the registers and register access over APB.
// Overview of operation
// - Respond only when chip bits match pins
// - Eighth select bit: 1 read, 0 write
// - Ack matched select in ninth slot; else standby
// - Large variants reuse chip bits as address
// - Write select, then address byte, both acked
// - Program only on Stop right after data ack
// - Ignore bus entirely while programming runs
// - Protect pin high before data: nack, no write
// - Page of 16; only low 4 bits increment
// - Reads ignore the write-protect pin
// - Random read: dummy write, restart, read select
// - Current read outputs counter byte, then increments
// - Master ack fetches next byte; nack ends
// - Read counter wraps from last to zero
// - No ack after read byte: release, standby
// - Array starts with every byte erased
// - Start: data falls, Stop: data rises, clock high
// - Sample data on clock rise, change when low
// - Floating protect pin reads as low
`include "eeprom_params.svh"
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_slave
  import eeprom_pkg::*;
#(
  parameter logic [3:0] TYPE_ID     = `TYPE_ID_DEFAULT,
  parameter int         PROG_CYCLES = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire bus
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Straps
  input  wire logic        chip_addr_pin_0,
  input  wire logic        chip_addr_pin_1,
  input  wire logic        chip_addr_pin_2,
  input  wire logic        write_protect_pin
);

  line_events_type        ev;
  straps_type             straps;
  state_type              state;
  kind_type               kind;
  logic [3:0]             cnt;
  logic [7:0]             shreg;
  logic                   drive_low;
  logic                   wp_seen;
  logic                   ten_slot;
  logic                   data_byte;
  logic [`MEM_ADDR_W-1:0] addr;
  logic [1:0]             ctrl_ext;
  logic                   busy;
  logic [7:0]             rd_data;

  line_watch u_watch (
    .pclk              (pclk),
    .presetn           (presetn),
    .scl               (scl),
    .sda_in            (sda_in),
    .write_protect_pin (write_protect_pin),
    .chip_pins         ({chip_addr_pin_2, chip_addr_pin_1, chip_addr_pin_0}),
    .ev                (ev),
    .straps            (straps)
  );

  // Wrap within the capacity that the variant setting exposes
  function automatic logic [`MEM_ADDR_W-1:0] incr_addr(
    input logic [`MEM_ADDR_W-1:0] a,
    input logic [`CHIP_BITS-1:0]  cmp_mask
  );
    logic [`MEM_ADDR_W-1:0] keep;
    keep = {~cmp_mask, {`LOW_ADDR_W{1'b1}}};
    incr_addr = (a + `MEM_ADDR_W'(1)) & keep;
  endfunction : incr_addr

  // Select decode
  wire [`CHIP_BITS-1:0] cmp_mask  = `CHIP_BITS'(3'h7 << ctrl_ext);
  wire [`CHIP_BITS-1:0] sel_chip  = shreg[3:1];
  wire                  sel_rw    = shreg[0];
  wire                  sel_match = (shreg[7:4] == TYPE_ID) &&
                                    (((sel_chip ^ straps.chip) & cmp_mask) == '0);
  wire [`MEM_ADDR_W-1:0] sel_addr = {sel_chip & ~cmp_mask, addr[`LOW_ADDR_W-1:0]};

  // Byte and slot decode
  wire byte_end  = (state == ST_RX) && ev.fall && (cnt == `BITS_PER_BYTE);
  wire ack_now   = (kind == K_SEL)  ? sel_match :
                   (kind == K_ADDR) ? 1'b1 : !wp_seen;
  wire pg_load   = byte_end && (kind == K_DATA) && !wp_seen;
  wire pg_clear  = byte_end && (kind == K_ADDR);
  wire prog_go   = ev.stop && ten_slot && !busy;
  wire tx_done   = (state == ST_TX) && ev.fall && (cnt == `BITS_PER_BYTE);
  wire [`MEM_ADDR_W-1:0] page_next =
    {addr[`MEM_ADDR_W-1:`PAGE_IDX_W], addr[`PAGE_IDX_W-1:0] + `PAGE_IDX_W'(1)};

  page_programmer #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_prog (
    .pclk        (pclk),
    .presetn     (presetn),
    .clear       (pg_clear),
    .load        (pg_load),
    .load_idx    (addr[`PAGE_IDX_W-1:0]),
    .load_data   (shreg),
    .commit      (prog_go),
    .commit_base (addr[`MEM_ADDR_W-1:`PAGE_IDX_W]),
    .busy        (busy),
    .rd_addr     (addr),
    .rd_data     (rd_data)
  );

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      kind      <= K_SEL;
      cnt       <= '0;
      shreg     <= '0;
      drive_low <= 1'b0;
      wp_seen   <= 1'b0;
      ten_slot  <= 1'b0;
      addr      <= '0;
      data_byte <= 1'b0;
    end else if (busy || ev.stop) begin
      state     <= ST_IDLE;
      drive_low <= 1'b0;
      ten_slot  <= 1'b0;
    end else if (ev.start) begin
      // A restart keeps the counter, so a dummy write steers the read
      state     <= ST_RX;
      kind      <= K_SEL;
      cnt       <= '0;
      drive_low <= 1'b0;
      ten_slot  <= 1'b0;
      wp_seen   <= straps.wp;
    end else begin
      // Tenth slot lasts until its clock falls, so a Stop in its high phase counts
      if (ev.fall) ten_slot <= 1'b0;
      unique case (state)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (ev.rise) begin
            shreg <= {shreg[6:0], ev.sda};
            cnt   <= cnt + 4'h1;
            if (kind != K_DATA) wp_seen <= wp_seen | straps.wp;
          end else if (byte_end) begin
            state     <= ST_ACK;
            cnt       <= '0;
            drive_low <= ack_now;
            data_byte <= (kind == K_DATA);
            if (kind == K_SEL && sel_match) begin
              kind <= sel_rw ? K_READ : K_ADDR;
              addr <= sel_addr;
            end else if (kind == K_ADDR) begin
              kind <= K_DATA;
              addr <= {addr[`MEM_ADDR_W-1:`LOW_ADDR_W], shreg};
            end else if (pg_load) begin
              addr <= page_next;
            end
          end
        end
        ST_ACK: begin
          if (ev.fall) begin
            cnt <= '0;
            if (!drive_low && kind != K_DATA) begin
              state     <= ST_IDLE;
              drive_low <= 1'b0;
            end else if (kind == K_READ) begin
              // Protect pin plays no part on the read path
              state     <= ST_TX;
              shreg     <= rd_data;
              drive_low <= ~rd_data[7];
            end else begin
              state     <= ST_RX;
              drive_low <= 1'b0;
              ten_slot  <= drive_low && data_byte;
            end
          end
        end
        ST_TX: begin
          if (ev.rise) begin
            cnt <= cnt + 4'h1;
          end else if (tx_done) begin
            state     <= ST_RACK;
            cnt       <= '0;
            drive_low <= 1'b0;
            addr      <= incr_addr(addr, cmp_mask);
          end else if (ev.fall) begin
            shreg     <= {shreg[6:0], 1'b0};
            drive_low <= ~shreg[6];
          end
        end
        ST_RACK: begin
          if (ev.rise) begin
            if (ev.sda) state <= ST_IDLE;
            else cnt <= 4'h1;
          end else if (ev.fall && cnt == 4'h1) begin
            state     <= ST_TX;
            cnt       <= '0;
            shreg     <= rd_data;
            drive_low <= ~rd_data[7];
          end
        end
      endcase
    end
  end

  // APB: zero wait states; read data captured in the setup cycle
  wire [`APB_OFS_W-1:0] ofs     = paddr[`APB_OFS_W-1:0];
  wire                  hit_ctl = (ofs == `REG_CTRL) && (paddr[31:`APB_OFS_W] == '0);
  wire                  hit_sts = (ofs == `REG_STATUS) && (paddr[31:`APB_OFS_W] == '0);
  wire                  setup   = psel && !penable;
  wire                  wr_ctl  = psel && penable && pwrite && hit_ctl;
  wire [31:0]           sts_word;

  assign sts_word = {5'h00, addr, 13'h0000, wp_seen, (state != ST_IDLE), busy};
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !(hit_ctl || hit_sts);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ext <= `CTRL_EXT_RESET;
      prdata   <= '0;
    end else begin
      if (wr_ctl) ctrl_ext <= pwdata[`CTRL_EXT_MSB:`CTRL_EXT_LSB];
      if (setup) prdata <= hit_ctl ? {30'h0, ctrl_ext} : hit_sts ? sts_word : 32'h0;
    end
  end

  // Checks
  drive_when_owned_a: assert property (@(posedge pclk) disable iff (!presetn)
    sda_oe |-> (state == ST_ACK || state == ST_TX))
    else $error("data line pulled outside ack or transmit");

  quiet_when_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy |=> !sda_oe && state == ST_IDLE)
    else $error("bus touched during programming");

  select_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_end && kind == K_SEL && !sel_match && !busy |=> !sda_oe ##1 !sda_oe)
    else $error("mismatched select acknowledged");

  select_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_end && kind == K_SEL && sel_match && !busy |=> sda_oe && state == ST_ACK)
    else $error("matched select not acknowledged");

  program_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> $past(ten_slot) && $past(ev.stop))
    else $error("programming started outside the tenth slot");

  protect_nack_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_end && kind == K_DATA && wp_seen |=> !sda_oe)
    else $error("data byte acknowledged while protected");

  page_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    pg_load |=> addr[`MEM_ADDR_W-1:`PAGE_IDX_W] == $past(addr[`MEM_ADDR_W-1:`PAGE_IDX_W]))
    else $error("page write moved the page");

  read_nack_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_RACK && ev.rise && ev.sda && !ev.stop |=> state == ST_IDLE ##1 !sda_oe)
    else $error("transmit continued after no ack");

  tenth_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.stop && !ten_slot && !busy |=> !busy)
    else $error("programming started by a stray stop");

  data_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_end && kind == K_DATA && !wp_seen && !busy |=> sda_oe)
    else $error("open data byte not acknowledged");

  address_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_end && kind == K_ADDR && !busy |=> sda_oe && kind == K_DATA)
    else $error("address byte not acknowledged");

  read_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_done && addr == '1 && cmp_mask == '0 |=> addr == '0)
    else $error("read counter did not wrap to zero");

  master_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_RACK |-> !sda_oe)
    else $error("data line held in master ack slot");

endmodule : serial_eeprom_slave
`default_nettype wire

// ==== serial_eeprom_slave_tb.sv ====
/*
  Self-checking bench of the two-wire EEPROM slave.
  Assumes the master model file and the design files are compiled first.
*/
`include "eeprom_params.svh"
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_slave_tb;
  localparam int         PROG = 400;
  localparam logic [3:0] TID  = `TYPE_ID_DEFAULT;
  typedef struct packed {
    logic [1:0] ext;
    logic [7:0] sel;
    logic       ack;
  } row_type;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        sda_out, sda_oe, wp, ack, e;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [2:0]  chip_pins;
  logic [7:0]  rb;
  wire         scl, pull_low, sda;
  int          fail_count, comparisons;
  row_type     rows [10] = '{
    '{2'd0, {TID, 3'b101, 1'b0}, 1'b1}, '{2'd0, {TID, 3'b100, 1'b0}, 1'b0},
    '{2'd0, {TID, 3'b001, 1'b1}, 1'b0}, '{2'd0, {TID, 3'b101, 1'b1}, 1'b1},
    '{2'd0, {TID ^ 4'h1, 3'b101, 1'b0}, 1'b0}, '{2'd1, {TID, 3'b100, 1'b0}, 1'b1},
    '{2'd1, {TID, 3'b110, 1'b0}, 1'b0}, '{2'd2, {TID, 3'b111, 1'b1}, 1'b1},
    '{2'd2, {TID, 3'b011, 1'b0}, 1'b0}, '{2'd3, {TID, 3'b010, 1'b0}, 1'b1}};

  // Pull-up wire: released by both parties reads high
  assign sda = ~(pull_low | (sda_oe & ~sda_out));

  serial_eeprom_slave #(.PROG_CYCLES(PROG)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_addr_pin_0(chip_pins[0]), .chip_addr_pin_1(chip_pins[1]),
    .chip_addr_pin_2(chip_pins[2]), .write_protect_pin(wp));
  bus_master_model m (.scl(scl), .pull_low(pull_low), .sda(sda));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 1, pready);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic sel(input logic rw, input logic [10:0] a);
    m.send({TID, a[10:8], rw}, ack);
    chk("select ack", 1, ack);
  endtask : sel

  task automatic wr_mem(input logic [10:0] a, input int n, input logic [23:0] d,
                        input logic exp);
    m.start_cond();
    sel(1'b0, a);
    m.send(a[7:0], ack);
    chk("addr ack", 1, ack);
    for (int i = 0; i < n; i++) begin
      m.send(d[23-8*i -: 8], ack);
      chk("data ack", exp, ack);
    end
    m.stop_cond();
  endtask : wr_mem

  task automatic rd_mem(input logic [10:0] a, input int n, input logic [23:0] d);
    m.start_cond();
    sel(1'b0, a);
    m.send(a[7:0], ack);
    chk("addr ack", 1, ack);
    m.start_cond();
    sel(1'b1, a);
    for (int i = 0; i < n; i++) begin
      m.recv(i < n - 1, rb);
      chk("read byte", d[23-8*i -: 8], rb);
    end
    m.stop_cond();
  endtask : rd_mem

  // Busy must show at once, then polling acks only once it ends
  task automatic wait_prog;
    int n;
    apb(1'b0, `REG_STATUS, 0);
    chk("busy", 1, q[`STAT_BUSY]);
    m.start_cond();
    m.send({TID, 3'b000, 1'b0}, ack);
    chk("poll nack", 0, ack);
    n = 0;
    while (ack !== 1'b1 && n < 40) begin
      m.start_cond();
      m.send({TID, 3'b000, 1'b0}, ack);
      n++;
    end
    m.stop_cond();
    chk("poll ack", 1, ack);
  endtask : wait_prog

  initial begin
    #200000;
    fail_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    chip_pins = 3'b101;
    wp = 1'b0; // Unconnected pin modelled as low
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b1, `REG_CTRL, {30'h0, rows[i].ext});
      m.start_cond();
      m.send(rows[i].sel, ack);
      chk("select ack", rows[i].ack, ack);
      if (ack && rows[i].sel[0]) begin
        m.recv(1'b0, rb);
      end
      m.stop_cond();
    end
    apb(1'b0, `REG_STATUS, 0);
    chk("busy after select", 0, q[`STAT_BUSY]);
    $display("test select table done");
    apb(1'b0, 32'h8, 0);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    apb(1'b1, `REG_CTRL, 32'h3);
    apb(1'b0, `REG_CTRL, 0);
    chk("ctrl ext", `CTRL_EXT_RESET, q[1:0]);
    $display("test registers done");
    // Three bytes end exactly at the page end, so nothing rolls over
    wr_mem(11'h7FD, 3, 24'h112233, 1'b1);
    wait_prog();
    wr_mem(11'h000, 1, 24'hA50000, 1'b1);
    wait_prog();
    rd_mem(11'h7FE, 2, 24'h223300);
    m.start_cond();
    m.send({TID, 3'b000, 1'b1}, ack);
    chk("current ack", 1, ack);
    m.recv(1'b0, rb);
    chk("current byte", 8'hA5, rb);
    m.stop_cond();
    rd_mem(11'h7FC, 2, 24'hFF1100);
    $display("test page write and reads done");
    @(posedge pclk);
    wp <= 1'b1;
    wr_mem(11'h020, 1, 24'h3C0000, 1'b0);
    apb(1'b0, `REG_STATUS, 0);
    chk("busy protected", 0, q[`STAT_BUSY]);
    chk("protect latched", 1, q[`STAT_WP]);
    chk("addr counter", 32'h020, q[`STAT_ADDR_MSB:`STAT_ADDR_LSB]);
    rd_mem(11'h020, 1, 24'hFF0000);
    @(posedge pclk);
    wp <= 1'b0;
    $display("test write protect done");
    // Reset in mid-run must erase the array and restore CTRL
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset data line", 0, sda_oe);
    chk("reset prdata", 0, prdata);
    presetn <= 1'b1;
    chip_pins <= 3'b010;
    repeat (3) @(posedge pclk);
    apb(1'b0, `REG_CTRL, 0);
    chk("reset ctrl", `CTRL_EXT_RESET, q[1:0]);
    rd_mem(11'h7FD, 1, 24'hFF0000);
    apb(1'b1, `REG_CTRL, 32'h0);
    m.start_cond();
    m.send({TID, 3'b010, 1'b0}, ack);
    chk("new pins ack", 1, ack);
    m.stop_cond();
    $display("test reset done");
    tally_and_finish();
  end
endmodule : serial_eeprom_slave_tb
`default_nettype wire
